// File: tb.sv
// Self-checking bench for the thermal supervisor.
// Assumes the decoded register port and the host model on the alarm pin.
`timescale 1ns/1ps
module tb;
  import tse_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       warn = 1'b0;
  logic       crit = 1'b0;
  logic       por = 1'b0;
  logic       gpi = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       alarm;
  logic       alarm_oe_n;
  logic       conv_en;
  logic       core_rst;
  logic       pin;
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #12.5 clk_sys = ~clk_sys;
  tse_thermal_supervisor dut (.clk_sys(clk_sys), .rst(rst), .temp_warn_cmp(warn),
    .thermal_critical_cmp(crit), .temp_por_cmp(por), .conv_ctrl_pin(gpi),
    .otp_masks_dflt(8'h00), .otp_conv_dflt(8'h01), .otp_almcfg_dflt(8'h04),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .alarm_output(alarm), .alarm_output_oe_n(alarm_oe_n), .converter_enable(conv_en),
    .core_reset(core_rst));
  tse_host_model host (.alarm_output(alarm), .alarm_output_oe_n(alarm_oe_n),
    .pin_level(pin));
  ////////////////////////////////////////////////////////////////////////////
  // Access and compare tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input string name, input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, rdata, e);
    @(posedge clk_sys);
  endtask
  // Pin, converter run and core reset together
  task automatic outs(input logic [2:0] e);
    @(negedge clk_sys);
    chk("pin_conv_reset", {5'h00, pin, conv_en, core_rst}, {5'h00, e});
    @(posedge clk_sys);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    wt(20);
    rst <= 1'b0;
    wt(2);
    rreg("masks", TSE_ADDR_MASKS, 8'h00);
    rreg("conv", TSE_ADDR_CONV, 8'h01);
    rreg("almcfg", TSE_ADDR_ALMCFG, 8'h04);
    rreg("unmapped", 9'h052, 8'h00);
    wreg(TSE_ADDR_STATUS, 8'hFF);
    rreg("status", TSE_ADDR_STATUS, 8'h00);
    outs(3'b110);
    // Warning, unmasked
    warn <= 1'b1;
    wt(10);
    rreg("status", TSE_ADDR_STATUS, 8'h04);
    rreg("events", TSE_ADDR_EVENTS, 8'h04);
    outs(3'b010);
    warn <= 1'b0;
    wt(10);
    rreg("status", TSE_ADDR_STATUS, 8'h00);
    rreg("events", TSE_ADDR_EVENTS, 8'h04);
    wreg(TSE_ADDR_EVENTS, 8'h0C);
    rreg("events", TSE_ADDR_EVENTS, 8'h00);
    outs(3'b110);
    // Warning, masked
    wreg(TSE_ADDR_MASKS, 8'h04);
    rreg("masks", TSE_ADDR_MASKS, 8'h04);
    warn <= 1'b1;
    wt(10);
    rreg("events", TSE_ADDR_EVENTS, 8'h04);
    outs(3'b110);
    wreg(TSE_ADDR_EVENTS, 8'h04);
    warn <= 1'b0;
    // Critical, unmasked, manual restart
    wreg(TSE_ADDR_MASKS, 8'h00);
    crit <= 1'b1;
    wt(10);
    outs(3'b000);
    rreg("status", TSE_ADDR_STATUS, 8'h08);
    rreg("events", TSE_ADDR_EVENTS, 8'h08);
    wreg(TSE_ADDR_CONV, 8'h01);
    wt(3);
    outs(3'b000);
    crit <= 1'b0;
    wt(10);
    rreg("status", TSE_ADDR_STATUS, 8'h00);
    outs(3'b000);
    wreg(TSE_ADDR_CONV, 8'h01);
    wt(3);
    outs(3'b010);
    wreg(TSE_ADDR_EVENTS, 8'h08);
    wt(3);
    outs(3'b110);
    // Critical, masked
    wreg(TSE_ADDR_MASKS, 8'h0C);
    crit <= 1'b1;
    wt(10);
    outs(3'b100);
    crit <= 1'b0;
    wt(10);
    wreg(TSE_ADDR_CONV, 8'h01);
    wreg(TSE_ADDR_EVENTS, 8'h08);
    wt(3);
    outs(3'b110);
    // Critical while the control pin steers the converter
    gpi <= 1'b1;
    wreg(TSE_ADDR_CONV, 8'h03);
    wt(10);
    outs(3'b110);
    crit <= 1'b1;
    wt(10);
    outs(3'b100);
    crit <= 1'b0;
    wt(10);
    outs(3'b100);
    gpi <= 1'b0;
    wt(10);
    outs(3'b100);
    gpi <= 1'b1;
    wt(10);
    outs(3'b110);
    wreg(TSE_ADDR_CONV, 8'h01);
    wreg(TSE_ADDR_EVENTS, 8'h08);
    gpi <= 1'b0;
    // Status mode, both polarities, then push-pull IRQ
    wreg(TSE_ADDR_MASKS, 8'h00);
    wreg(TSE_ADDR_ALMCFG, 8'h01);
    wt(3);
    outs(3'b010);
    warn <= 1'b1;
    wt(10);
    outs(3'b110);
    warn <= 1'b0;
    wt(10);
    outs(3'b010);
    wreg(TSE_ADDR_ALMCFG, 8'h00);
    wt(3);
    outs(3'b110);
    wreg(TSE_ADDR_ALMCFG, 8'h06);
    wreg(TSE_ADDR_EVENTS, 8'h04);
    wt(3);
    @(negedge clk_sys);
    chk("alarm_oe_n", {7'h00, alarm_oe_n}, 8'h00);
    wreg(TSE_ADDR_ALMCFG, 8'h04);
    wt(3);
    outs(3'b110);
    // Clearing write near a rising warning
    for (int k = 1; k <= 6; k++) begin
      warn <= 1'b1;
      wt(k);
      // Write at or before the rise keeps the event, after it clears it
      wreg(TSE_ADDR_EVENTS, 8'h0C);
      wt(8);
      rreg("events", TSE_ADDR_EVENTS, (k <= 3) ? 8'h04 : 8'h00);
      wreg(TSE_ADDR_EVENTS, 8'h04);
      warn <= 1'b0;
      wt(8);
    end
    // Reset level
    warn <= 1'b1;
    wt(10);
    warn <= 1'b0;
    por <= 1'b1;
    wt(10);
    outs(3'b101);
    por <= 1'b0;
    wt(10);
    rreg("events", TSE_ADDR_EVENTS, 8'h00);
    outs(3'b110);
    results();
  end
endmodule

// File: tse_host_model.sv
// Host side of the alarm pin.
// Assumes a pull-up on the pin and low-active interrupt signalling.
`timescale 1ns/1ps
module tse_host_model (
  input  wire logic alarm_output,
  input  wire logic alarm_output_oe_n,
  output logic      pin_level
);
  // Released pin floats to the pull-up level
  assign pin_level = alarm_output_oe_n ? 1'b1 : alarm_output;
endmodule

// File: tse_pkg.sv
// Constants for the thermal supervision event block.
// Assumes a byte-wide register port with nine address bits.
package tse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int          TSE_ADDR_W  = 9;
  localparam int          TSE_DATA_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [8:0]  TSE_ADDR_STATUS  = 9'h051;
  localparam logic [8:0]  TSE_ADDR_EVENTS  = 9'h053;
  localparam logic [8:0]  TSE_ADDR_MASKS   = 9'h055;
  localparam logic [8:0]  TSE_ADDR_CONV    = 9'h05D;
  localparam logic [8:0]  TSE_ADDR_ALMCFG  = 9'h143;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in status, events and masks
  localparam int          TSE_BIT_WARN     = 2;
  localparam int          TSE_BIT_CRIT     = 3;

  // Field positions in converter_control
  localparam int          TSE_BIT_CONV_ON  = 0;
  localparam int          TSE_BIT_GPI_LO   = 1;
  localparam int          TSE_BIT_GPI_HI   = 2;

  // Field positions in alarm_pin_config
  localparam int          TSE_BIT_ALM_POL  = 0;
  localparam int          TSE_BIT_ALM_TYPE = 1;
  localparam int          TSE_BIT_ALM_IRQ  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed reset values; events keep theirs, the others apply until the programmable defaults load
  localparam logic [7:0]  TSE_RST_MASKS    = 8'h00;
  localparam logic [7:0]  TSE_RST_CONV     = 8'h00;
  localparam logic [7:0]  TSE_RST_ALMCFG   = 8'h04;
  localparam logic [7:0]  TSE_RST_EVENTS   = 8'h00;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0]  TSE_WMASK_MASKS  = 8'h0C;
  localparam logic [7:0]  TSE_WMASK_CONV   = 8'h07;
  localparam logic [7:0]  TSE_WMASK_ALMCFG = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  localparam int          TSE_SYNC_STAGES  = 3;
  localparam int          TSE_NUM_IN       = 4;
  localparam int          TSE_IN_WARN      = 0;
  localparam int          TSE_IN_CRIT      = 1;
  localparam int          TSE_IN_POR       = 2;
  localparam int          TSE_IN_GPI       = 3;

endpackage

// File: tse_supervisor_properties.sv
// Port timing checker for the thermal supervisor.
// Assumes it is bound to the supervisor top module.
`timescale 1ns/1ps
module tse_supervisor_properties
  import tse_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       temp_warn_cmp,
  input wire logic       thermal_critical_cmp,
  input wire logic       temp_por_cmp,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       converter_enable,
  input wire logic       core_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       warn_r;
  logic [3:0] warn_cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since warning rose, no writes since
  always_ff @(posedge clk_sys) begin
    warn_r <= rst ? 1'b1 : temp_warn_cmp;
    if (rst || reg_wr || !temp_warn_cmp) begin
      warn_cnt_r <= 4'h0;
    end else if (!warn_r) begin
      warn_cnt_r <= 4'h1;
    end else if (warn_cnt_r != 4'h0 && warn_cnt_r != 4'hF) begin
      warn_cnt_r <= warn_cnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_crit_hold;
    thermal_critical_cmp [*6] |-> !converter_enable;
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("converter ran in overheat");
  property p_crit_sync;
    $rose(thermal_critical_cmp) && converter_enable |=> converter_enable [*2];
  endproperty
  a_crit_sync: assert property (p_crit_sync) else $error("shutdown bypassed sync");
  property p_por_on;
    temp_por_cmp [*6] |-> core_reset;
  endproperty
  a_por_on: assert property (p_por_on) else $error("core reset missing");
  property p_por_off;
    $fell(temp_por_cmp) ##1 (!temp_por_cmp) [*7] |-> !core_reset;
  endproperty
  a_por_off: assert property (p_por_off) else $error("core reset stuck");
  property p_warn_status;
    $stable(temp_warn_cmp) [*8] ##0 (reg_rd && reg_addr == TSE_ADDR_STATUS)
      |=> reg_rdata[TSE_BIT_WARN] == $past(temp_warn_cmp);
  endproperty
  a_warn_status: assert property (p_warn_status) else $error("warning status wrong");
  property p_crit_status;
    $stable(thermal_critical_cmp) [*8] ##0 (reg_rd && reg_addr == TSE_ADDR_STATUS)
      |=> reg_rdata[TSE_BIT_CRIT] == $past(thermal_critical_cmp);
  endproperty
  a_crit_status: assert property (p_crit_status) else $error("critical status wrong");
  property p_warn_event;
    reg_rd && reg_addr == TSE_ADDR_EVENTS && warn_cnt_r >= 4'h8
      |=> reg_rdata[TSE_BIT_WARN];
  endproperty
  a_warn_event: assert property (p_warn_event) else $error("warning event lost");
  property p_evt_clear;
    (!temp_warn_cmp && !thermal_critical_cmp) [*8] ##0
      (reg_wr && reg_addr == TSE_ADDR_EVENTS && reg_wdata[3:2] == 2'b11) ##[1:2]
      (reg_rd && reg_addr == TSE_ADDR_EVENTS) |=> reg_rdata[3:2] == 2'b00;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("events not cleared");
endmodule
bind tse_thermal_supervisor tse_supervisor_properties u_chk (.clk_sys, .rst,
  .temp_warn_cmp, .thermal_critical_cmp, .temp_por_cmp, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .converter_enable, .core_reset);

// File: tse_thermal_supervisor.sv
// Thermal supervision: status, events, alarm pin, converter shutdown
// and core reset driven by three on-die temperature comparators.
// Assumes the serial control port delivers decoded one-cycle read and
// write strobes with address and data, and comparators are asynchronous.
`timescale 1ns/1ps

// Functional notes
// RL1: Supervise three rising thresholds: warning, critical, reset.
// RL2: Warning onset sets status and latches event.
// RL3: Unmasked warning event drives alarm pin active.
// RL4: Warning status follows comparator level exactly.
// RL5: Critical onset forces converter off immediately.
// RL6: Critical onset sets status, latches maskable event.
// RL7: Critical status follows comparator level exactly.
// RL8: Converter held off while critical flag active.
// RL9: Restart needs converter_on write or pin toggle.
// RL10: Reset level asserts core reset until cleared.
// RL11: Some reset values load from programmable memory.
// RL12: Write-back clears events; concurrent events are delayed.
// RL13: Status mode: events on rising edge, selectable polarity.
// RL14: Comparator flags synchronised before any use.
module tse_thermal_supervisor
  import tse_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Asynchronous comparator flags and converter control pin
  input  wire logic                  temp_warn_cmp,
  input  wire logic                  thermal_critical_cmp,
  input  wire logic                  temp_por_cmp,
  input  wire logic                  conv_ctrl_pin,
  // Programmable defaults, valid from power-up
  input  wire logic [7:0]            otp_masks_dflt,
  input  wire logic [7:0]            otp_conv_dflt,
  input  wire logic [7:0]            otp_almcfg_dflt,
  // Decoded register port
  input  wire logic [TSE_ADDR_W-1:0] reg_addr,
  input  wire logic [TSE_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [TSE_DATA_W-1:0] reg_rdata,
  // Device-side outputs
  output logic                       alarm_output,
  output logic                       alarm_output_oe_n,
  output logic                       converter_enable,
  output logic                       core_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [TSE_NUM_IN-1:0] sync1_r;
  logic [TSE_NUM_IN-1:0] sync2_r;
  logic [TSE_NUM_IN-1:0] sync3_r;
  logic [TSE_NUM_IN-1:0] level_r;
  logic [TSE_NUM_IN-1:0] level_nxt;
  logic                  por_level_r;
  logic                  core_rst;
  logic                  otp_load_r;
  logic [7:0]            status;
  logic [7:0]            status_prev_r;
  logic [7:0]            rise;
  logic [7:0]            events_r;
  logic [7:0]            events_nxt;
  logic [7:0]            pending_r;
  logic [7:0]            masks_r;
  logic [7:0]            conv_r;
  logic [7:0]            almcfg_r;
  logic                  wr_events;
  logic                  wr_masks;
  logic                  wr_conv;
  logic                  wr_almcfg;
  logic                  gpi_prev_r;
  logic                  gpi_toggle;
  logic                  gpi_selected;
  logic                  thermal_lock_r;
  logic                  restart_req;
  logic                  run_request;
  logic                  alarm_active;
  logic [7:0]            rdata_r;
  logic                  alarm_r;
  logic                  conv_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match for a write or read strobe
  function automatic logic hit(input logic [TSE_ADDR_W-1:0] a,
                               input logic [TSE_ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // Keep only the writable bits of new data; the other bits become zero
  function automatic logic [7:0] merge(input logic [7:0] data,
                                       input logic [7:0] wmask);
    merge = data & wmask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, accept once stages two and three agree

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= {conv_ctrl_pin, temp_por_cmp, thermal_critical_cmp, temp_warn_cmp};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Filtered levels change only when the last two stages agree
  always_comb begin
    for (int i = 0; i < TSE_NUM_IN; i++) begin
      level_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : level_r[i];
    end
  end

  // Filtered comparator and pin levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core reset from the reset-level comparator

  // Held for as long as the over-temperature persists
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_level_r <= 1'b0;
    end else begin
      por_level_r <= level_r[TSE_IN_POR]; // RL10
    end
  end

  // Everything below halts while the core is held in reset
  assign core_rst = rst | por_level_r; // RL10

  ////////////////////////////////////////////////////////////////////////////
  // Programmable defaults load in the first cycle after reset

  // Load flag, set by reset and cleared once defaults are in
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      otp_load_r <= 1'b1;
    end else begin
      otp_load_r <= 1'b0; // RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and event detection

  // Status bits follow the filtered comparator levels
  always_comb begin
    status               = 8'h00;
    status[TSE_BIT_WARN] = level_r[TSE_IN_WARN]; // RL1 RL4
    status[TSE_BIT_CRIT] = level_r[TSE_IN_CRIT]; // RL1 RL7
  end

  // Previous status for inactive-to-active detection
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      status_prev_r <= 8'h00;
    end else begin
      status_prev_r <= status;
    end
  end

  // Events are raised only on a rising status bit
  assign rise = status & ~status_prev_r; // RL13

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  assign wr_events = reg_wr & hit(reg_addr, TSE_ADDR_EVENTS);
  assign wr_masks  = reg_wr & hit(reg_addr, TSE_ADDR_MASKS);
  assign wr_conv   = reg_wr & hit(reg_addr, TSE_ADDR_CONV);
  assign wr_almcfg = reg_wr & hit(reg_addr, TSE_ADDR_ALMCFG);

  ////////////////////////////////////////////////////////////////////////////
  // Event register with write-back clear

  // New events during a clearing write wait one cycle in pending
  always_comb begin
    if (wr_events) begin
      events_nxt = events_r & ~reg_wdata; // RL12
    end else begin
      events_nxt = events_r | rise | pending_r; // RL2 RL6
    end
  end

  // Latched events
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      events_r <= TSE_RST_EVENTS;
    end else begin
      events_r <= events_nxt;
    end
  end

  // Holding stage for events that coincide with a clear
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      pending_r <= 8'h00;
    end else if (wr_events) begin
      pending_r <= pending_r | rise; // RL12
    end else begin
      pending_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask, converter control and alarm pin configuration

  // Mask register, default from programmable memory
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      masks_r <= TSE_RST_MASKS;
    end else if (otp_load_r) begin
      masks_r <= merge(otp_masks_dflt, TSE_WMASK_MASKS); // RL11
    end else if (wr_masks) begin
      masks_r <= merge(reg_wdata, TSE_WMASK_MASKS);
    end
  end

  // Converter control register, default from programmable memory
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      conv_r <= TSE_RST_CONV;
    end else if (otp_load_r) begin
      conv_r <= merge(otp_conv_dflt, TSE_WMASK_CONV); // RL11
    end else if (wr_conv) begin
      conv_r <= merge(reg_wdata, TSE_WMASK_CONV);
    end
  end

  // Alarm pin configuration, default from programmable memory
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      almcfg_r <= TSE_RST_ALMCFG;
    end else if (otp_load_r) begin
      almcfg_r <= merge(otp_almcfg_dflt, TSE_WMASK_ALMCFG); // RL11
    end else if (wr_almcfg) begin
      almcfg_r <= merge(reg_wdata, TSE_WMASK_ALMCFG);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter shutdown and managed restart

  // Control pin steers the converter when a pin is selected
  assign gpi_selected = |conv_r[TSE_BIT_GPI_HI:TSE_BIT_GPI_LO];

  // Previous pin level for toggle detection
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      gpi_prev_r <= 1'b0;
    end else begin
      gpi_prev_r <= level_r[TSE_IN_GPI];
    end
  end

  assign gpi_toggle  = gpi_selected & (gpi_prev_r != level_r[TSE_IN_GPI]);

  // Restart needs a fresh enable write or a pin toggle
  assign restart_req = (wr_conv & reg_wdata[TSE_BIT_CONV_ON]) | gpi_toggle; // RL9

  // Lock set on critical; survives cooling until a restart request
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      thermal_lock_r <= 1'b0;
    end else if (level_r[TSE_IN_CRIT]) begin
      thermal_lock_r <= 1'b1; // RL8
    end else if (restart_req) begin
      thermal_lock_r <= 1'b0; // RL9
    end
  end

  // Requested run state from pin or register
  assign run_request = gpi_selected ? level_r[TSE_IN_GPI] : conv_r[TSE_BIT_CONV_ON];

  // Critical overrides register and pin without software action
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      conv_en_r <= 1'b0;
    end else if (level_r[TSE_IN_CRIT]) begin
      conv_en_r <= 1'b0; // RL5 RL8
    end else if (thermal_lock_r & ~restart_req) begin
      conv_en_r <= 1'b0; // RL9
    end else begin
      conv_en_r <= run_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm pin

  // IRQ mode: unmasked latched events; status mode: unmasked status
  always_comb begin
    if (almcfg_r[TSE_BIT_ALM_IRQ]) begin
      alarm_active = |(events_r & ~masks_r); // RL3 RL6
    end else begin
      alarm_active = |(status & ~masks_r); // RL13
    end
  end

  // Pin level: IRQ is active low, status mode uses the polarity bit
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      alarm_r <= 1'b1;
    end else if (almcfg_r[TSE_BIT_ALM_IRQ]) begin
      alarm_r <= ~alarm_active; // RL3
    end else begin
      alarm_r <= almcfg_r[TSE_BIT_ALM_POL] ? alarm_active : ~alarm_active; // RL13
    end
  end

  // Open-drain type releases the pin unless it pulls low in IRQ mode; status mode and push-pull type always drive it
  logic oe_n_r;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      oe_n_r <= 1'b1;
    end else if (almcfg_r[TSE_BIT_ALM_TYPE]) begin
      oe_n_r <= 1'b0;
    end else if (almcfg_r[TSE_BIT_ALM_IRQ]) begin
      oe_n_r <= ~alarm_active;
    end else begin
      oe_n_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data one cycle after the read strobe

  // Unmapped addresses and reserved bits return zero
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, TSE_ADDR_STATUS)) begin
        rdata_r <= status;
      end else if (hit(reg_addr, TSE_ADDR_EVENTS)) begin
        rdata_r <= events_r;
      end else if (hit(reg_addr, TSE_ADDR_MASKS)) begin
        rdata_r <= masks_r;
      end else if (hit(reg_addr, TSE_ADDR_CONV)) begin
        rdata_r <= conv_r;
      end else if (hit(reg_addr, TSE_ADDR_ALMCFG)) begin
        rdata_r <= almcfg_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop
  assign reg_rdata         = rdata_r;
  assign alarm_output      = alarm_r;
  assign alarm_output_oe_n = oe_n_r;
  assign converter_enable  = conv_en_r;
  assign core_reset        = por_level_r;

endmodule
